// File: famc_top.sv
/*
  Flash array model behind its control lines, with an AXI4-Lite register slave for
  write protection, live status and sticky error flags.
  Assumes the control lines come from logic on clk_i and need no synchroniser.
*/
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module famc_top (
  input wire logic clk_i,
  input wire logic rstn_i,
  // array control lines
  input wire logic row_enable_i,
  input wire logic column_enable_i,
  input wire logic sense_amp_enable_i,
  input wire logic output_drive_enable_i,
  input wire logic program_select_i,
  input wire logic erase_select_i,
  input wire logic whole_array_select_i,
  input wire logic store_strobe_i,
  input wire logic info_block_select_i,
  input wire logic [famc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [famc_pkg::DATA_W-1:0] wdata_i,
  output logic [famc_pkg::DATA_W-1:0] rdata_o,
  output logic rdata_oe_o,
  // register bus
  input wire logic [famc_pkg::BUS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [famc_pkg::BUS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef struct packed {
    logic [famc_pkg::WORDS-1:0][famc_pkg::DATA_W-1:0] mem;
    logic [famc_pkg::WORDS-1:0] programmed;
    famc_pkg::famc_mode_e prev_mode;
    logic [famc_pkg::DATA_W-1:0] rdata;
    logic rdata_oe;
    logic store_en;
    logic [famc_pkg::ERR_W-1:0] err;
    logic aw_got;
    logic [famc_pkg::BUS_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rd;
    logic [1:0] rresp;
  } famc_state_s;

  famc_state_s q;
  famc_state_s n;
  famc_ctl_if ctl ();

  // lines into the shared bundle
  assign ctl.row_enable = row_enable_i;
  assign ctl.column_enable = column_enable_i;
  assign ctl.sense_amp_enable = sense_amp_enable_i;
  assign ctl.output_drive_enable = output_drive_enable_i;
  assign ctl.program_select = program_select_i;
  assign ctl.erase_select = erase_select_i;
  assign ctl.whole_array_select = whole_array_select_i;
  assign ctl.store_strobe = store_strobe_i;
  assign ctl.info_block_select = info_block_select_i;

  famc_mode_dec u_dec (
    .ctl(ctl)
  );

  // word index: info block sits above the main block
  function automatic logic [famc_pkg::IDX_W-1:0] word_index(input logic info, input logic [famc_pkg::ADDR_W-1:0] a);
    if (info) begin
      word_index = famc_pkg::IDX_W'(famc_pkg::MAIN_WORDS) + famc_pkg::IDX_W'(a[famc_pkg::PAGE_LSB-1:0]);
    end else begin
      word_index = famc_pkg::IDX_W'(a);
    end
  endfunction : word_index

  // word-aligned register decode, low two address bits ignored
  function automatic logic [famc_pkg::BUS_ADDR_W-1:0] reg_of(input logic [famc_pkg::BUS_ADDR_W-1:0] a);
    reg_of = {a[famc_pkg::BUS_ADDR_W-1:2], 2'h0};
  endfunction : reg_of

  famc_pkg::famc_mode_e mode;
  logic [famc_pkg::IDX_W-1:0] idx;
  logic entry;
  logic store_op;
  logic [famc_pkg::ERR_W-1:0] err_set;
  logic [famc_pkg::ERR_W-1:0] err_clr;

  // next state of array, flags and bus slave
  always_comb begin
    n = q;
    mode = ctl.mode;
    idx = word_index(info_block_select_i, addr_i);
    entry = (mode != q.prev_mode);
    store_op = entry && (mode == famc_pkg::MODE_PROGRAM || mode == famc_pkg::MODE_PAGE_ERASE ||
                         mode == famc_pkg::MODE_MASS_ERASE);
    err_set = '0;
    err_clr = '0;
    n.prev_mode = mode;

    // read path: data driven only in read, muxed only with row and column enabled
    n.rdata_oe = output_drive_enable_i && (mode == famc_pkg::MODE_READ);
    n.rdata = '0;
    if (mode == famc_pkg::MODE_READ && row_enable_i && column_enable_i) begin
      n.rdata = q.mem[idx];
    end

    // pattern checks on the incoming lines
    if (mode == famc_pkg::MODE_ILLEGAL) begin
      err_set[famc_pkg::ERR_ILLEGAL_BIT] = 1'b1;
    end
    if (entry && mode != famc_pkg::MODE_STANDBY && q.prev_mode != famc_pkg::MODE_STANDBY) begin
      err_set[famc_pkg::ERR_NO_STANDBY_BIT] = 1'b1;
    end
    if (store_op && !q.store_en) begin
      err_set[famc_pkg::ERR_PROTECT_BIT] = 1'b1;
    end

    // program and erase act a single time, on entry into the pattern
    if (store_op && q.store_en && row_enable_i) begin
      if (mode == famc_pkg::MODE_PROGRAM) begin
        if (q.programmed[idx]) begin
          err_set[famc_pkg::ERR_REPROGRAM_BIT] = 1'b1;
        end
        n.mem[idx] = q.mem[idx] & wdata_i;
        n.programmed[idx] = 1'b1;
      end else begin
        for (int i = 0; i < famc_pkg::WORDS; i++) begin
          if ((mode == famc_pkg::MODE_MASS_ERASE && (i < famc_pkg::MAIN_WORDS || info_block_select_i)) ||
              (mode == famc_pkg::MODE_PAGE_ERASE && (i < famc_pkg::MAIN_WORDS) != info_block_select_i &&
               (info_block_select_i || i[famc_pkg::ADDR_W-1:famc_pkg::PAGE_LSB] ==
                addr_i[famc_pkg::ADDR_W-1:famc_pkg::PAGE_LSB]))) begin
            n.mem[i] = famc_pkg::ERASED_WORD;
            n.programmed[i] = 1'b0;
          end
        end
      end
    end

    // write channel: address and data taken in either order
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s_axi_awvalid && q.awready) begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_got = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = famc_pkg::RESP_OKAY;
      case (reg_of(q.aw_addr))
        famc_pkg::REG_CTRL: begin
          if (q.w_strb[0]) begin
            n.store_en = q.w_data[famc_pkg::CTRL_STORE_EN_BIT];
          end
        end
        famc_pkg::REG_ERR: begin
          if (q.w_strb[0]) begin
            err_clr = q.w_data[famc_pkg::ERR_W-1:0];
          end
        end
        famc_pkg::REG_STATUS: ;
        default: n.bresp = famc_pkg::RESP_DECERR;
      endcase
    end
    n.err = (q.err & ~err_clr) | err_set; // set wins over clear
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;

    // read channel
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = famc_pkg::RESP_OKAY;
      n.rd = '0;
      case (reg_of(s_axi_araddr))
        famc_pkg::REG_CTRL: n.rd[famc_pkg::CTRL_STORE_EN_BIT] = q.store_en;
        famc_pkg::REG_STATUS: begin
          n.rd[famc_pkg::STAT_MODE_LSB +: 3] = q.prev_mode;
          n.rd[famc_pkg::STAT_INFO_BIT] = info_block_select_i;
          n.rd[famc_pkg::STAT_DRIVE_BIT] = q.rdata_oe;
        end
        famc_pkg::REG_ERR: n.rd[famc_pkg::ERR_W-1:0] = q.err;
        default: n.rresp = famc_pkg::RESP_DECERR;
      endcase
    end
    n.arready = !n.rvalid;
  end

  // single state register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.mem <= {famc_pkg::WORDS{famc_pkg::ERASED_WORD}};
      q.prev_mode <= famc_pkg::MODE_STANDBY;
      q.store_en <= famc_pkg::CTRL_RESET;
    end else begin
      q <= n;
    end
  end

  // outputs straight from the state register
  assign rdata_o = q.rdata;
  assign rdata_oe_o = q.rdata_oe;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rd;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;

endmodule : famc_top
`default_nettype wire

// File: famc_pkg.sv
/*
  Shared constants for the flash array mode control block: control line patterns,
  array geometry, register offsets and fields, bus response codes.
  Assumes nothing of its surroundings; every other file refers to it by famc_pkg::name.
*/
package famc_pkg;

  // array geometry: main block of pages, info block of one page
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;
  localparam int PAGE_LSB = 3;
  localparam int MAIN_WORDS = 32;
  localparam int INFO_WORDS = 8;
  localparam int WORDS = MAIN_WORDS + INFO_WORDS;
  localparam int IDX_W = 6;
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;

  // control line patterns, order {row, column, sense, drive, program, erase, whole, store}
  localparam logic [7:0] PAT_STANDBY = 8'h00;
  localparam logic [7:0] PAT_READ = 8'hf0;
  localparam logic [7:0] PAT_PROGRAM = 8'hc9;
  localparam logic [7:0] PAT_PAGE_ERASE = 8'h85;
  localparam logic [7:0] PAT_MASS_ERASE = 8'h87;

  typedef enum logic [2:0] {
    MODE_STANDBY,
    MODE_READ,
    MODE_PROGRAM,
    MODE_PAGE_ERASE,
    MODE_MASS_ERASE,
    MODE_ILLEGAL
  } famc_mode_e;

  // register map, byte addresses
  localparam int BUS_ADDR_W = 8;
  localparam logic [BUS_ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [BUS_ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [BUS_ADDR_W-1:0] REG_ERR = 8'h08;
  localparam logic CTRL_RESET = 1'h1;
  localparam int CTRL_STORE_EN_BIT = 0;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_INFO_BIT = 3;
  localparam int STAT_DRIVE_BIT = 4;
  localparam int ERR_W = 4;
  localparam int ERR_ILLEGAL_BIT = 0;
  localparam int ERR_NO_STANDBY_BIT = 1;
  localparam int ERR_REPROGRAM_BIT = 2;
  localparam int ERR_PROTECT_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : famc_pkg

// File: famc_ctl_if.sv
/*
  Bundle of the eight array control lines, the info block select and the decoded mode.
  Assumes the top module drives the lines and the decoder returns the mode.
*/
`timescale 1ns/1ps
`default_nettype none
interface famc_ctl_if;
  logic row_enable;
  logic column_enable;
  logic sense_amp_enable;
  logic output_drive_enable;
  logic program_select;
  logic erase_select;
  logic whole_array_select;
  logic store_strobe;
  logic info_block_select;
  famc_pkg::famc_mode_e mode;

  modport drv (output row_enable, column_enable, sense_amp_enable, output_drive_enable, program_select,
               erase_select, whole_array_select, store_strobe, info_block_select, input mode);
  modport dec (input row_enable, column_enable, sense_amp_enable, output_drive_enable, program_select,
               erase_select, whole_array_select, store_strobe, info_block_select, output mode);
endinterface : famc_ctl_if
`default_nettype wire

// File: famc_mode_dec.sv
/*
  Decodes the eight control lines into one array mode.
  Assumes the lines are already on the block's clock; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module famc_mode_dec (
  famc_ctl_if.dec ctl
);

  // exact match against the defined patterns; anything else is illegal
  function automatic famc_pkg::famc_mode_e decode(input logic [7:0] pat);
    case (pat)
      famc_pkg::PAT_STANDBY: decode = famc_pkg::MODE_STANDBY;
      famc_pkg::PAT_READ: decode = famc_pkg::MODE_READ;
      famc_pkg::PAT_PROGRAM: decode = famc_pkg::MODE_PROGRAM;
      famc_pkg::PAT_PAGE_ERASE: decode = famc_pkg::MODE_PAGE_ERASE;
      famc_pkg::PAT_MASS_ERASE: decode = famc_pkg::MODE_MASS_ERASE;
      default: decode = famc_pkg::MODE_ILLEGAL;
    endcase
  endfunction : decode

  // line bundle in fixed order
  always_comb begin
    ctl.mode = decode({ctl.row_enable, ctl.column_enable, ctl.sense_amp_enable, ctl.output_drive_enable,
                       ctl.program_select, ctl.erase_select, ctl.whole_array_select, ctl.store_strobe});
  end

endmodule : famc_mode_dec
`default_nettype wire

// File: famc_top_monitor.sv
/* port checker for famc_top
   bound from the bench top file; one clock domain */
`timescale 1ns/1ps
`default_nettype none
module famc_top_monitor (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic row_enable_i,
  input wire logic column_enable_i,
  input wire logic sense_amp_enable_i,
  input wire logic output_drive_enable_i,
  input wire logic program_select_i,
  input wire logic erase_select_i,
  input wire logic whole_array_select_i,
  input wire logic store_strobe_i,
  input wire logic [15:0] rdata_o,
  input wire logic rdata_oe_o,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  logic [7:0] ln;
  // live pattern in package bit order
  assign ln = {row_enable_i, column_enable_i, sense_amp_enable_i, output_drive_enable_i,
               program_select_i, erase_select_i, whole_array_select_i, store_strobe_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  chk_read_drive: assert property (ln == famc_pkg::PAT_READ |=> rdata_oe_o)
    else $error("no drive after read");
  chk_drive_cause: assert property (rdata_oe_o |-> $past(ln) == famc_pkg::PAT_READ)
    else $error("drive without read");
  chk_row_off: assert property (!row_enable_i |=> !rdata_oe_o)
    else $error("drive with rows off");
  chk_col_off: assert property (!column_enable_i |=> !rdata_oe_o)
    else $error("drive with columns off");
  chk_idle_zero: assert property (!rdata_oe_o |-> rdata_o == 16'h0000)
    else $error("data while released");
  chk_r_after: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read answer");
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken in response");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken in response");
endmodule : famc_top_monitor
`default_nettype wire

// File: famc_ctl_model.sv
/* far-side model: the flash interface unit driving the array lines
   takes req_i only while busy_o is low */
`timescale 1ns/1ps
`default_nettype none
// store patterns at 50 MHz: 15 us covers strobe setup plus hold, 100 us for mass erase
module famc_ctl_model #(parameter int HOLD = 4, parameter int OP_HOLD = 750, parameter int MASS_HOLD = 5000) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic req_i,
  input wire logic [7:0] pat_i,
  input wire logic info_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [7:0] lines_o,
  output logic info_o,
  output logic [4:0] addr_o,
  output logic [15:0] wdata_o,
  output logic busy_o
);
  int cnt = 0;
  initial {lines_o, info_o, addr_o, wdata_o, busy_o} = '0;
  // one op: pattern held HOLD+1 cycles, OP_HOLD+1 with store strobe, MASS_HOLD+1 for mass erase, then standby
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      {lines_o, info_o, addr_o, wdata_o, busy_o} <= '0;
      cnt <= 0;
    end else if (!busy_o && req_i) begin
      {lines_o, info_o, addr_o, wdata_o} <= {pat_i, info_i, addr_i, wdata_i};
      busy_o <= 1'b1;
      if (pat_i == famc_pkg::PAT_MASS_ERASE) begin
        cnt <= MASS_HOLD;
      end else if (pat_i[0]) begin
        cnt <= OP_HOLD;
      end else begin
        cnt <= HOLD;
      end
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end else if (lines_o != 8'h00) begin
      lines_o <= 8'h00;
      {addr_o, wdata_o} <= ~{addr_o, wdata_o}; // released bus
    end else begin
      busy_o <= 1'b0;
    end
  end
endmodule : famc_ctl_model
`default_nettype wire

// File: famc_top_tb.sv
/* bench for famc_top: array lines via the far-side model, registers via AXI4-Lite
   assumes famc_pkg, the model and the monitor are compiled first */
`timescale 1ns/1ps
`default_nettype none
module famc_top_tb;
  logic clk_i, rstn_i, row_enable_i, column_enable_i, sense_amp_enable_i, output_drive_enable_i;
  logic program_select_i, erase_select_i, whole_array_select_i, store_strobe_i, info_block_select_i;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rdata_oe_o, req, busy, inf;
  logic [7:0] s_axi_awaddr, s_axi_araddr, lines, pat;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [15:0] rdata_o, wdata_i, dat;
  logic [4:0] addr_i, adr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_fail, cmp_count;
  assign {row_enable_i, column_enable_i, sense_amp_enable_i, output_drive_enable_i,
          program_select_i, erase_select_i, whole_array_select_i, store_strobe_i} = lines;
  famc_top u_famc_top (.*);
  famc_ctl_model u_famc_ctl_model (.clk_i, .rstn_i, .req_i(req), .pat_i(pat), .info_i(inf),
    .addr_i(adr), .wdata_i(dat), .lines_o(lines), .info_o(info_block_select_i), .addr_o(addr_i),
    .wdata_o(wdata_i), .busy_o(busy));
  task automatic give_verdict();
    $display("compares %0d, errors %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      n_fail++;
      $display("Error %0t: wait ran out", $time);
      give_verdict();
    end
  endtask : tmo
  // register write, bad selects the decode error answer
  task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic bad);
    int n;
    n = 0;
    @(posedge clk_i);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    tmo(n, 50);
    cmp(s_axi_bresp, bad ? famc_pkg::RESP_DECERR : famc_pkg::RESP_OKAY);
  endtask : wreg
  // register read with data and answer check
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic bad);
    int n;
    n = 0;
    @(posedge clk_i);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    tmo(n, 50);
    cmp(s_axi_rdata, e);
    cmp(s_axi_rresp, bad ? famc_pkg::RESP_DECERR : famc_pkg::RESP_OKAY);
  endtask : rreg
  task automatic idle();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (busy && n < 6000);
    tmo(n, 6000);
  endtask : idle
  task automatic op(input logic [7:0] p, input logic f, input logic [4:0] a, input logic [15:0] d);
    idle();
    @(posedge clk_i);
    {req, pat, inf, adr, dat} <= {1'b1, p, f, a, d};
    @(posedge clk_i);
    req <= 1'b0;
  endtask : op
  // array read: data one edge after the pattern, bus released after
  task automatic frd(input logic f, input logic [4:0] a, input logic [15:0] e);
    op(famc_pkg::PAT_READ, f, a, 16'h0000);
    @(posedge clk_i);
    #1;
    cmp(rdata_o, e);
    cmp(rdata_oe_o, 1'b1);
    idle();
    #1;
    cmp(rdata_oe_o, 1'b0);
  endtask : frd
  // reset values, unmapped and read-only places
  task automatic t_regs();
    logic [31:0] st;
    st = (32'(famc_pkg::MODE_READ) << famc_pkg::STAT_MODE_LSB) | (32'h1 << famc_pkg::STAT_INFO_BIT) |
         (32'h1 << famc_pkg::STAT_DRIVE_BIT);
    op(famc_pkg::PAT_READ, 1'b1, 5'h00, 16'h0000);
    rreg(famc_pkg::REG_STATUS, st, 1'b0);
    rreg(famc_pkg::REG_CTRL, 32'h1, 1'b0);
    rreg(famc_pkg::REG_ERR, 32'h0, 1'b0);
    rreg(8'h0c, 32'h0, 1'b1);
    wreg(8'h0c, 32'h1, 1'b1);
    wreg(famc_pkg::REG_STATUS, 32'h1f, 1'b0);
  endtask : t_regs
  // program both blocks, then a second program of one word
  task automatic t_program_select();
    frd(1'b0, 5'h05, 16'hffff);
    op(famc_pkg::PAT_PROGRAM, 1'b0, 5'h05, 16'h1234);
    op(famc_pkg::PAT_PROGRAM, 1'b1, 5'h05, 16'h00ff);
    frd(1'b0, 5'h05, 16'h1234);
    frd(1'b1, 5'h05, 16'h00ff);
    op(famc_pkg::PAT_PROGRAM, 1'b0, 5'h05, 16'hff00);
    frd(1'b0, 5'h05, 16'h1200);
    rreg(famc_pkg::REG_ERR, 32'h1 << famc_pkg::ERR_REPROGRAM_BIT, 1'b0);
    wreg(famc_pkg::REG_ERR, 32'hf, 1'b0);
  endtask : t_program_select
  // page erase on the main block, mass erase on each block select
  task automatic t_erase();
    op(famc_pkg::PAT_PAGE_ERASE, 1'b0, 5'h05, 16'h0000);
    frd(1'b0, 5'h05, 16'hffff);
    frd(1'b1, 5'h05, 16'h00ff);
    op(famc_pkg::PAT_PROGRAM, 1'b0, 5'h10, 16'h0000);
    op(famc_pkg::PAT_MASS_ERASE, 1'b0, 5'h00, 16'h0000);
    frd(1'b0, 5'h10, 16'hffff);
    frd(1'b1, 5'h05, 16'h00ff);
    op(famc_pkg::PAT_MASS_ERASE, 1'b1, 5'h00, 16'h0000);
    frd(1'b1, 5'h05, 16'hffff);
    rreg(famc_pkg::REG_ERR, 32'h0, 1'b0);
  endtask : t_erase
  // store blocked, then an undefined pattern
  task automatic t_refuse();
    wreg(famc_pkg::REG_CTRL, 32'h0, 1'b0);
    op(famc_pkg::PAT_PROGRAM, 1'b0, 5'h01, 16'h0000);
    frd(1'b0, 5'h01, 16'hffff);
    rreg(famc_pkg::REG_ERR, 32'h1 << famc_pkg::ERR_PROTECT_BIT, 1'b0);
    wreg(famc_pkg::REG_CTRL, 32'h1, 1'b0);
    wreg(famc_pkg::REG_ERR, 32'hf, 1'b0);
    op(8'h40, 1'b0, 5'h00, 16'h0000);
    idle();
    rreg(famc_pkg::REG_ERR, 32'h1 << famc_pkg::ERR_ILLEGAL_BIT, 1'b0);
  endtask : t_refuse
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // reset, scenarios, verdict
  initial begin
    {rstn_i, req, pat, inf, adr, dat, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    n_fail = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_program_select();
    t_erase();
    t_refuse();
    give_verdict();
  end
endmodule : famc_top_tb
bind famc_top famc_top_monitor u_famc_top_monitor (.*);
`default_nettype wire
